// [shared/serial_bus_unit_pkg.sv]
// Constants, register map and field layout of the serial bus unit control block
// Overview of operation
// - Two serial modes: multi-master two-wire bus, and clocked shift of 1 to 8 data bits.
// - Control zero bit 7 enables the unit, resets 0; set before other writes.
// - Control zero bits 0 to 6 are read-only zero.
// - Three-bit rate select picks divider exponent 5 to 11; code 111 reserved.
// - Control one bit 0 reads the soft reset monitor, not the written bit.
// - Bit count 000 means 8 data bits; 001 to 111 mean 1 to 7.
// - Acknowledge bit adds one clock cycle beyond the data length.
// - Monitor bit reads 1 after reset; rate bit 0 becomes 0 entering shift mode.
// - Mode field: 00 port, 01 shift, 10 two-wire bus, 11 reserved.
package serial_bus_unit_pkg;
	localparam logic [31:0] CTRL_ONE_IDX = 32'hFFFFF250;
	localparam logic [31:0] CTRL_TWO_IDX = 32'hFFFFF253;
	localparam logic [31:0] CTRL_ZERO_IDX = 32'hFFFFF257;
	localparam logic [31:0] BURST_CTRL_IDX = 32'hFFFFF25F;
	localparam int ENABLE_BIT = 7;
	localparam int BIT_COUNT_LSB = 5;
	localparam int ACK_BIT = 4;
	localparam int FIXED_ONE_BIT = 3;
	localparam int MODE_LSB = 2;
	localparam int SOFT_RESET_LSB = 0;
	localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
	localparam logic [2:0] RATE_RESET = 3'h1;
	localparam logic [2:0] RATE_RESERVED = 3'h7;
	localparam logic [1:0] MODE_PORT = 2'h0;
	localparam logic [1:0] MODE_SHIFT = 2'h1;
	localparam logic [1:0] MODE_BUS = 2'h2;
	localparam logic [1:0] SOFT_RESET_FIRST = 2'h2;
	localparam logic [1:0] SOFT_RESET_SECOND = 2'h1;
	localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;
	localparam logic [3:0] EXP_BASE = 4'h5;
	localparam logic [11:0] HALF_PERIOD_OFFSET = 12'h046;
	localparam logic [3:0] FULL_BYTE_BITS = 4'h8;
endpackage

// [hw/serial_clock_burst.sv]
// Serial clock burst generator: a fixed number of divided clock cycles per start
`timescale 1ns/1ps
module serial_clock_burst (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic [2:0] rate_i,
	input wire logic [3:0] cycles_i,
	output logic sclk_o,
	output logic busy_o,
	output logic done_o
);
	typedef enum logic [1:0] {IDLE, LOW_HALF, HIGH_HALF} burst_state_e;

	burst_state_e state;
	logic [11:0] half_count;
	logic [11:0] half_load;
	logic [3:0] cycles_left;
	logic [3:0] exponent;
	wire half_done = (half_count == 12'h001);
	wire start_ok = start_i && (rate_i != serial_bus_unit_pkg::RATE_RESERVED) && (cycles_i != 4'h0);

	assign exponent = serial_bus_unit_pkg::EXP_BASE + {1'b0, rate_i};
	assign half_load = (12'h001 << exponent) + serial_bus_unit_pkg::HALF_PERIOD_OFFSET;

	always_ff @(posedge clk_i) begin
		if (rst_i || abort_i) begin
			state <= IDLE;
			half_count <= 12'h000;
			cycles_left <= 4'h0;
			sclk_o <= 1'b1;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			unique case (state)
				IDLE: begin
					if (start_ok) begin
						state <= LOW_HALF;
						half_count <= half_load;
						cycles_left <= cycles_i;
						sclk_o <= 1'b0;
						busy_o <= 1'b1;
					end
				end
				LOW_HALF: begin
					half_count <= half_done ? half_load : half_count - 12'h001;
					if (half_done) begin
						state <= HIGH_HALF;
						sclk_o <= 1'b1;
					end
				end
				HIGH_HALF: begin
					half_count <= half_done ? half_load : half_count - 12'h001;
					if (half_done) begin
						if (cycles_left == 4'h1) begin
							state <= IDLE;
							busy_o <= 1'b0;
							done_o <= 1'b1;
						end else begin
							state <= LOW_HALF;
							sclk_o <= 1'b0;
						end
						cycles_left <= cycles_left - 4'h1;
					end
				end
				default: state <= IDLE;
			endcase
		end
	end
endmodule

// [hw/serial_bus_unit_control.sv]
// Control front end of the serial bus unit with a classic Wishbone register slave
`timescale 1ns/1ps
module serial_bus_unit_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic unit_enable_o,
	output logic [1:0] operating_mode_o,
	output logic soft_reset_busy_o,
	output logic burst_busy_o,
	output logic scl_o,
	output logic scl_oe_o
);
	logic unit_enable_bit;
	logic [2:0] bit_count_field;
	logic ack_enable;
	logic [2:0] scl_rate_select;
	logic [1:0] operating_mode_field;
	logic [1:0] soft_reset_last;
	logic [3:0] soft_reset_count;
	logic burst_start;
	logic sclk;
	logic sclk_busy;
	logic sclk_done;
	logic burst_done_flag;
	logic [3:0] data_length;
	logic [3:0] clock_cycles;
	logic [7:0] read_byte;
	logic next_scl_o;
	logic next_scl_oe;

	// Bus decode
	wire access = cyc_i && stb_i && !ack_o;
	wire wr_lane = access && we_i && sel_i[0];
	wire hit_zero = (adr_i == serial_bus_unit_pkg::CTRL_ZERO_IDX);
	wire hit_one = (adr_i == serial_bus_unit_pkg::CTRL_ONE_IDX);
	wire hit_two = (adr_i == serial_bus_unit_pkg::CTRL_TWO_IDX);
	wire hit_burst = (adr_i == serial_bus_unit_pkg::BURST_CTRL_IDX);
	wire soft_reset_active = (soft_reset_count != 4'h0);
	// only the enable register is writable while disabled
	wire wr_allowed = wr_lane && unit_enable_bit;
	wire wr_zero = wr_lane && hit_zero;
	wire wr_one = wr_allowed && hit_one && !soft_reset_active;
	wire wr_two = wr_allowed && hit_two;
	wire wr_burst = wr_allowed && hit_burst && !soft_reset_active;
	wire [1:0] new_mode = dat_i[serial_bus_unit_pkg::MODE_LSB +: 2];
	wire [1:0] new_soft_reset = dat_i[serial_bus_unit_pkg::SOFT_RESET_LSB +: 2];
	// Any other write to control two in between disarms the key
	// Second half of the two-write key starts the soft reset
	wire soft_reset_key = wr_two && (new_soft_reset == serial_bus_unit_pkg::SOFT_RESET_SECOND)
		&& (soft_reset_last == serial_bus_unit_pkg::SOFT_RESET_FIRST);
	// entering shift mode zeroes the low rate bit
	wire enter_shift = wr_two && (new_mode == serial_bus_unit_pkg::MODE_SHIFT)
		&& (operating_mode_field != serial_bus_unit_pkg::MODE_SHIFT);
	wire serial_mode = (operating_mode_field == serial_bus_unit_pkg::MODE_SHIFT)
		|| (operating_mode_field == serial_bus_unit_pkg::MODE_BUS);
	// Soft reset and disable both cut a running burst short, so no half clock is left on the pin
	wire burst_abort = soft_reset_active || !unit_enable_bit;

	// code 000 means a full byte
	assign data_length = (bit_count_field == 3'h0) ? serial_bus_unit_pkg::FULL_BYTE_BITS : {1'b0, bit_count_field};
	assign clock_cycles = data_length + {3'h0, ack_enable};
	// A burst only starts in a serial mode with the unit enabled
	assign burst_start = wr_burst && dat_i[0] && serial_mode;

	// low bits of control zero read zero
	// bit 0 of control one shows the reset monitor
	wire [7:0] zero_view = {unit_enable_bit, 7'h00};
	wire [7:0] one_view = {bit_count_field, ack_enable, 1'b1, scl_rate_select[2:1], !soft_reset_active};
	wire [7:0] two_view = {4'h0, operating_mode_field, 2'h0};
	wire [7:0] burst_view = {6'h00, burst_done_flag, sclk_busy};
	assign read_byte = hit_zero ? zero_view :
		hit_one ? one_view :
		hit_two ? two_view :
		hit_burst ? burst_view : 8'h00;

	// open-drain clock in bus mode, push-pull clock in shift mode
	always_comb begin
		next_scl_o = 1'b1;
		next_scl_oe = 1'b0;
		if (unit_enable_bit && operating_mode_field == serial_bus_unit_pkg::MODE_SHIFT) begin
			next_scl_o = sclk;
			next_scl_oe = 1'b1;
		end else if (unit_enable_bit && operating_mode_field == serial_bus_unit_pkg::MODE_BUS) begin
			next_scl_o = 1'b0;
			next_scl_oe = !sclk;
		end
	end

	serial_clock_burst burst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(burst_start),
		.abort_i(burst_abort),
		.rate_i(scl_rate_select),
		.cycles_i(clock_cycles),
		.sclk_o(sclk),
		.busy_o(sclk_busy),
		.done_o(sclk_done)
	);

	// Bus answer one cycle after the request is taken; ack gates the decode so a held strobe is never acked on two cycles in a row
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= access;
		end
	end

	// Read data stands only with ack; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else begin
			dat_o <= access ? {24'h000000, read_byte} : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_enable_bit <= 1'b0;
		end else if (wr_zero) begin
			unit_enable_bit <= dat_i[serial_bus_unit_pkg::ENABLE_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_active) begin
			bit_count_field <= serial_bus_unit_pkg::BIT_COUNT_RESET;
			ack_enable <= 1'b0;
		end else if (wr_one) begin
			bit_count_field <= dat_i[serial_bus_unit_pkg::BIT_COUNT_LSB +: 3];
			ack_enable <= dat_i[serial_bus_unit_pkg::ACK_BIT];
		end
	end

	// rate bit 0 resets to 1
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset_active) begin
			scl_rate_select <= serial_bus_unit_pkg::RATE_RESET;
		end else if (wr_one) begin
			scl_rate_select <= dat_i[2:0];
		end else if (enter_shift) begin
			scl_rate_select[0] <= 1'b0;
		end
	end

	// mode field; reserved code is not taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			operating_mode_field <= serial_bus_unit_pkg::MODE_PORT;
		end else if (wr_two && new_mode != 2'h3) begin
			operating_mode_field <= new_mode;
		end
	end

	// soft reset sequence and its monitor
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_reset_last <= 2'h0;
			soft_reset_count <= 4'h0;
		end else begin
			if (wr_two) begin
				soft_reset_last <= new_soft_reset;
			end
			if (soft_reset_key) begin
				soft_reset_count <= serial_bus_unit_pkg::SOFT_RESET_CYCLES;
			end else if (soft_reset_active) begin
				soft_reset_count <= soft_reset_count - 4'h1;
			end
		end
	end

	// Burst done flag: a new completion wins over the clear by write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			burst_done_flag <= 1'b0;
		end else if (sclk_done) begin
			burst_done_flag <= 1'b1;
		end else if (wr_burst && dat_i[1]) begin
			burst_done_flag <= 1'b0;
		end
	end

	// Registered pin outputs, released after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_o <= 1'b1;
			scl_oe_o <= 1'b0;
		end else begin
			scl_o <= next_scl_o;
			scl_oe_o <= next_scl_oe;
		end
	end

	// Registered status outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_enable_o <= 1'b0;
			operating_mode_o <= serial_bus_unit_pkg::MODE_PORT;
			soft_reset_busy_o <= 1'b0;
			burst_busy_o <= 1'b0;
		end else begin
			unit_enable_o <= unit_enable_bit;
			operating_mode_o <= operating_mode_field;
			soft_reset_busy_o <= soft_reset_active;
			burst_busy_o <= sclk_busy;
		end
	end
endmodule

// [verif/serial_bus_unit_props.sv]
// Checker for the serial bus unit control ports
`timescale 1ns/1ps
module serial_bus_unit_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic unit_enable_o,
	input wire logic [1:0] operating_mode_o,
	input wire logic soft_reset_busy_o,
	input wire logic burst_busy_o,
	input wire logic scl_o,
	input wire logic scl_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_sr_run;
		soft_reset_busy_o[*8] ##1 !soft_reset_busy_o;
	endsequence
	chk_ack_next: assert property (s_req |=> ack_o) else $error("request not acked");
	chk_ack_drop: assert property (ack_o |=> !ack_o) else $error("ack held");
	chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
	chk_dat_upper: assert property (dat_o[31:8] == 24'h0) else $error("upper read bits set");
	chk_port_quiet: assert property ((operating_mode_o == 2'h0)[*3] |-> !scl_oe_o && scl_o)
		else $error("clock driven in port mode");
	chk_bus_drain: assert property ((operating_mode_o == 2'h2)[*3] |-> !(scl_oe_o && scl_o))
		else $error("bus clock driven high");
	chk_shift_drive: assert property ((unit_enable_o && operating_mode_o == 2'h1)[*3] |-> scl_oe_o)
		else $error("shift clock not driven");
	chk_idle_high: assert property ((!burst_busy_o)[*3] |-> !scl_oe_o || scl_o)
		else $error("idle clock low");
	chk_sr_len: assert property ($rose(soft_reset_busy_o) |-> s_sr_run) else $error("soft reset length");
endmodule

// [verif/serial_clock_peer.sv]
// Far-side clock listener with pull-up on the clock line
`timescale 1ns/1ps
module serial_clock_peer (
	input wire logic clk_i,
	input wire logic scl_i,
	input wire logic scl_oe_i,
	output logic [15:0] rises_o,
	output logic [15:0] period_o
);
	logic line;
	logic last = 1'b1;
	logic [15:0] now = 16'h0;
	logic [15:0] stamp = 16'h0;
	initial rises_o = 16'h0;
	initial period_o = 16'h0;
	assign line = scl_oe_i ? scl_i : 1'b1;
	always @(posedge clk_i) begin
		now <= now + 16'h1;
		last <= line;
		if (line && !last) begin
			rises_o <= rises_o + 16'h1;
			period_o <= now - stamp;
			stamp <= now;
		end
	end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the serial bus unit control
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic [1:0] md; logic [2:0] bc; logic ak; logic [2:0] rt; logic [15:0] n, p;} row_s;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, unit_enable_o;
	logic soft_reset_busy_o, burst_busy_o, scl_o, scl_oe_o;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, q;
	logic [1:0] operating_mode_o;
	logic [15:0] rises, period, r0;
	int err_total = 0, checks = 0, n;
	row_s rows [6] = '{'{2'h1, 3'h0, 1'h0, 3'h0, 16'h0008, 16'h00CC}, '{2'h1, 3'h0, 1'h1, 3'h1, 16'h0009, 16'h010C},
		'{2'h1, 3'h1, 1'h0, 3'h0, 16'h0001, 16'h0000}, '{2'h1, 3'h3, 1'h1, 3'h2, 16'h0004, 16'h018C},
		'{2'h1, 3'h7, 1'h0, 3'h0, 16'h0007, 16'h00CC}, '{2'h2, 3'h2, 1'h1, 3'h3, 16'h0003, 16'h028C}};
	always #5 clk_i = ~clk_i;
	serial_bus_unit_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .unit_enable_o(unit_enable_o),
		.operating_mode_o(operating_mode_o), .soft_reset_busy_o(soft_reset_busy_o),
		.burst_busy_o(burst_busy_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o));
	serial_clock_peer i_peer (.clk_i(clk_i), .scl_i(scl_o), .scl_oe_i(scl_oe_o), .rises_o(rises), .period_o(period));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Holds the request until ack is sampled high at a rising edge, takes the data and releases at that edge
	task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, 24'h0, d, 4'hF};
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1) break;
		end
		if (k == 20) err_total++;
		q = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask
	// Starts one clock burst, waits for its end, then counts rising edges and the last period
	task automatic run_burst(input logic [15:0] ne, input logic [15:0] pe);
		r0 = rises;
		wb(1, serial_bus_unit_pkg::BURST_CTRL_IDX, 8'h01);
		@(negedge clk_i);
		chk(burst_busy_o, 1);
		for (n = 0; n < 20000 && burst_busy_o !== 1'b0; n++) @(negedge clk_i);
		if (n == 20000) err_total++;
		repeat (4) @(negedge clk_i);
		chk(rises - r0, ne);
		if (pe != 16'h0) chk(period, pe);
	endtask
	task automatic end_sim;
		$display("errors=%0d checks=%0d", err_total, checks);
		if (err_total == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	initial begin
		#300000;
		err_total++;
		end_sim();
	end
	initial begin
		do_reset();
		wb(1, serial_bus_unit_pkg::CTRL_ZERO_IDX, 8'h80);
		// bit count still 000 when shift mode is first entered
		// pins idle high in port mode before leaving it
		foreach (rows[i]) begin
			wb(1, serial_bus_unit_pkg::CTRL_TWO_IDX, {4'h0, rows[i].md, 2'h0});
			wb(1, serial_bus_unit_pkg::CTRL_ONE_IDX, {rows[i].bc, rows[i].ak, 1'b0, rows[i].rt});
			run_burst(rows[i].n, rows[i].p);
		end
		wb(1, serial_bus_unit_pkg::CTRL_ONE_IDX, 8'h07);
		wb(1, serial_bus_unit_pkg::BURST_CTRL_IDX, 8'h01);
		@(negedge clk_i);
		chk(burst_busy_o, 0);
		wb(1, serial_bus_unit_pkg::CTRL_TWO_IDX, 8'h0C);
		@(negedge clk_i);
		chk(operating_mode_o, serial_bus_unit_pkg::MODE_BUS);
		wb(1, serial_bus_unit_pkg::CTRL_ONE_IDX, 8'hE0);
		wb(0, serial_bus_unit_pkg::CTRL_ONE_IDX, 8'h0);
		chk(q, 32'hE9);
		// bus is free when port mode is chosen
		wb(1, serial_bus_unit_pkg::CTRL_TWO_IDX, 8'h02);
		wb(1, serial_bus_unit_pkg::CTRL_TWO_IDX, 8'h01);
		wb(0, serial_bus_unit_pkg::CTRL_ONE_IDX, 8'h0);
		chk(q, 32'h08);
		for (n = 0; n < 50 && soft_reset_busy_o !== 1'b0; n++) @(negedge clk_i);
		if (n == 50) err_total++;
		wb(0, serial_bus_unit_pkg::CTRL_ONE_IDX, 8'h0);
		chk(q, 32'h09);
		// soft reset left bit count at 000 before shift mode
		wb(1, serial_bus_unit_pkg::CTRL_TWO_IDX, 8'h04);
		run_burst(16'h0008, 16'h00CC);
		wb(0, 32'h00000000, 8'h0);
		chk(q, 32'h0);
		do_reset();
		wb(0, serial_bus_unit_pkg::CTRL_ZERO_IDX, 8'h0);
		chk(q, 32'h0);
		wb(1, serial_bus_unit_pkg::CTRL_ONE_IDX, 8'hE0);
		wb(0, serial_bus_unit_pkg::CTRL_ONE_IDX, 8'h0);
		chk(q, 32'h09);
		wb(1, serial_bus_unit_pkg::CTRL_ZERO_IDX, 8'hFF);
		wb(0, serial_bus_unit_pkg::CTRL_ZERO_IDX, 8'h0);
		chk(q, 32'h80);
		end_sim();
	end
endmodule
bind serial_bus_unit_control serial_bus_unit_props i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .unit_enable_o(unit_enable_o), .operating_mode_o(operating_mode_o),
	.soft_reset_busy_o(soft_reset_busy_o), .burst_busy_o(burst_busy_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o));
